//--- hdl/mic_cfg_regs.sv
module mic_cfg_regs
    import mic_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_cfg_req,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_smbus,
    input  wire logic [9:0]  i_cfg_idx,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    output logic             o_cfg_ack,
    output logic [31:0]      o_cfg_rdata,
    output logic             o_ext_req,
    output logic             o_ext_wr,
    output logic [9:0]       o_ext_idx,
    output logic [3:0]       o_ext_be,
    output logic [31:0]      o_ext_wdata,
    input  wire logic        i_ext_ack,
    input  wire logic [31:0] i_ext_rdata,
    input  wire logic        i_wr_unlock,
    input  wire logic        i_msi_enable,
    input  wire logic [29:0] i_lower_msg_address,
    input  wire logic        i_msi_fire,
    output logic             o_mw_valid,
    output logic [63:0]      o_mw_addr,
    output logic             o_mw_addr64,
    output logic [31:0]      o_mw_data,
    output logic             o_mw_upstream
);

    mic_state_e  state_r;
    logic [31:0] upper_msg_address_reg_r;
    logic [15:0] msg_payload_r;
    logic [7:0]  next_capability_pointer_r;
    logic [31:0] subsystem_ids_r;
    logic [5:0]  register_number_r;
    logic [3:0]  extended_page_number_r;

    logic [9:0]  win_idx;
    logic [9:0]  acc_idx;
    logic        is_data;
    logic        is_local;
    logic [31:0] local_rd;
    logic        take;
    logic        win_dead;
    logic        go_ext;
    logic        wr_en;
    logic [31:0] wr_val;

    function automatic logic [31:0] merge_be(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic idx_local(input logic [9:0] idx);
        return (idx == MIC_IDX_UPPER_ADDR) || (idx == MIC_IDX_MSG_DATA) ||
               (idx == MIC_IDX_SUBSYSTEM_FIELD_CAP) || (idx == MIC_IDX_SUBSYSTEM_FIELD) ||
               (idx == MIC_IDX_IND_ADDR);
    endfunction

    // window target index
    assign win_idx = {extended_page_number_r, register_number_r};
    assign is_data = (i_cfg_idx == MIC_IDX_IND_DATA);
    assign acc_idx = is_data ? win_idx : i_cfg_idx;
    assign is_local = idx_local(acc_idx);
    assign take = i_cfg_req && (state_r == MIC_ST_IDLE);
    // data register through the window, or any smbus data access
    assign win_dead = is_data &&
        (i_cfg_smbus || (win_idx == MIC_IDX_IND_DATA));
    assign go_ext = take && is_data && !win_dead && !is_local;
    assign wr_en = take && i_cfg_wr && !win_dead && is_local;
    assign wr_val = merge_be(local_rd, i_cfg_wdata, i_cfg_be);

    // local read decode, reserved bits zero
    always_comb
    begin
        local_rd = 32'h0000_0000;
        unique case (acc_idx)
            MIC_IDX_UPPER_ADDR:
            begin
                local_rd = upper_msg_address_reg_r;
            end
            MIC_IDX_MSG_DATA:
            begin
                local_rd[MIC_PAYLOAD_W-1:0] = msg_payload_r;
            end
            MIC_IDX_SUBSYSTEM_FIELD_CAP:
            begin
                local_rd[MIC_CAP_CODE_LSB +: 8] = MIC_CAP_CODE;
                local_rd[MIC_NXT_PTR_LSB +: 8] = next_capability_pointer_r;
            end
            MIC_IDX_SUBSYSTEM_FIELD:
            begin
                local_rd = subsystem_ids_r;
            end
            MIC_IDX_IND_ADDR:
            begin
                local_rd[MIC_IND_REG_LSB +: 6] = register_number_r;
                local_rd[MIC_IND_PAGE_LSB +: 4] =
                    extended_page_number_r;
            end
            default:
            begin
                local_rd = 32'h0000_0000;
            end
        endcase
    end

    // request sequencing
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r <= MIC_ST_IDLE;
        end
        else
        begin
            unique case (state_r)
                MIC_ST_IDLE:
                begin
                    if (go_ext)
                    begin
                        state_r <= MIC_ST_EXT;
                    end
                end
                MIC_ST_EXT:
                begin
                    if (i_ext_ack)
                    begin
                        state_r <= MIC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // answer to the requester
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_cfg_ack   <= 1'b0;
            o_cfg_rdata <= 32'h0000_0000;
        end
        else
        begin
            o_cfg_ack   <= 1'b0;
            o_cfg_rdata <= 32'h0000_0000;
            if (state_r == MIC_ST_EXT)
            begin
                if (i_ext_ack)
                begin
                    o_cfg_ack   <= 1'b1;
                    o_cfg_rdata <= o_ext_wr ? 32'h0000_0000
                                            : i_ext_rdata;
                end
            end
            else if (take && !go_ext)
            begin
                o_cfg_ack <= 1'b1;
                if (!i_cfg_wr && !win_dead)
                begin
                    o_cfg_rdata <= local_rd;
                end
            end
        end
    end

    // forwarded window access to the rest of the configuration space
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_ext_req   <= 1'b0;
            o_ext_wr    <= 1'b0;
            o_ext_idx   <= 10'h000;
            o_ext_be    <= 4'h0;
            o_ext_wdata <= 32'h0000_0000;
        end
        else if (go_ext)
        begin
            o_ext_req   <= 1'b1;
            o_ext_wr    <= i_cfg_wr;
            o_ext_idx   <= win_idx;
            o_ext_be    <= i_cfg_be;
            o_ext_wdata <= i_cfg_wdata;
        end
        else if (i_ext_ack)
        begin
            o_ext_req <= 1'b0;
        end
    end

    // interrupt address and data registers
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            upper_msg_address_reg_r <= MIC_RST_UPPER_ADDR;
            msg_payload_r           <= MIC_RST_MSG_DATA;
        end
        else if (wr_en)
        begin
            if (acc_idx == MIC_IDX_UPPER_ADDR)
            begin
                upper_msg_address_reg_r <= wr_val;
            end
            if (acc_idx == MIC_IDX_MSG_DATA)
            begin
                msg_payload_r <= wr_val[MIC_PAYLOAD_W-1:0];
            end
        end
    end

    // subsystem identification, lockable
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            next_capability_pointer_r <= MIC_RST_NXT_PTR;
            subsystem_ids_r           <= MIC_RST_SUBSYSTEM_FIELD;
        end
        else if (wr_en && i_wr_unlock)
        begin
            if (acc_idx == MIC_IDX_SUBSYSTEM_FIELD_CAP)
            begin
                next_capability_pointer_r <=
                    wr_val[MIC_NXT_PTR_LSB +: 8];
            end
            if (acc_idx == MIC_IDX_SUBSYSTEM_FIELD)
            begin
                subsystem_ids_r <= wr_val;
            end
        end
    end

    // indirect address register
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            register_number_r      <= MIC_RST_IND_REG;
            extended_page_number_r <= MIC_RST_IND_PAGE;
        end
        else if (wr_en && (acc_idx == MIC_IDX_IND_ADDR))
        begin
            register_number_r      <= wr_val[MIC_IND_REG_LSB +: 6];
            extended_page_number_r <= wr_val[MIC_IND_PAGE_LSB +: 4];
        end
    end

    // interrupt memory write generation
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_mw_valid    <= 1'b0;
            o_mw_addr     <= 64'h0000_0000_0000_0000;
            o_mw_addr64   <= 1'b0;
            o_mw_data     <= 32'h0000_0000;
            o_mw_upstream <= 1'b0;
        end
        else
        begin
            o_mw_valid    <= i_msi_fire && i_msi_enable;
            o_mw_upstream <= i_msi_fire && i_msi_enable;
            if (i_msi_fire && i_msi_enable)
            begin
                o_mw_addr[31:0] <= {i_lower_msg_address, 2'b00};
                if (upper_msg_address_reg_r != 32'h0000_0000)
                begin
                    o_mw_addr[63:32] <= upper_msg_address_reg_r;
                    o_mw_addr64      <= 1'b1;
                end
                else
                begin
                    o_mw_addr[63:32] <= 32'h0000_0000;
                    o_mw_addr64      <= 1'b0;
                end
                o_mw_data <= {16'h0000, msg_payload_r};
            end
        end
    end

endmodule

//--- shared/mic_pkg.sv
package mic_pkg;

    // register byte offsets within the port configuration space
    localparam logic [11:0] MIC_OFS_UPPER_ADDR = 12'h0d8;
    localparam logic [11:0] MIC_OFS_MSG_DATA   = 12'h0dc;
    localparam logic [11:0] MIC_OFS_SUBSYSTEM_FIELD_CAP   = 12'h0f0;
    localparam logic [11:0] MIC_OFS_SUBSYSTEM_FIELD       = 12'h0f4;
    localparam logic [11:0] MIC_OFS_IND_ADDR   = 12'h0f8;
    localparam logic [11:0] MIC_OFS_IND_DATA   = 12'h0fc;

    // doubleword indices of the same registers
    localparam logic [9:0] MIC_IDX_UPPER_ADDR = MIC_OFS_UPPER_ADDR[11:2];
    localparam logic [9:0] MIC_IDX_MSG_DATA   = MIC_OFS_MSG_DATA[11:2];
    localparam logic [9:0] MIC_IDX_SUBSYSTEM_FIELD_CAP   = MIC_OFS_SUBSYSTEM_FIELD_CAP[11:2];
    localparam logic [9:0] MIC_IDX_SUBSYSTEM_FIELD       = MIC_OFS_SUBSYSTEM_FIELD[11:2];
    localparam logic [9:0] MIC_IDX_IND_ADDR   = MIC_OFS_IND_ADDR[11:2];
    localparam logic [9:0] MIC_IDX_IND_DATA   = MIC_OFS_IND_DATA[11:2];

    // field positions
    localparam int MIC_CAP_CODE_LSB = 0;
    localparam int MIC_NXT_PTR_LSB  = 8;
    localparam int MIC_SVID_LSB     = 0;
    localparam int MIC_SID_LSB      = 16;
    localparam int MIC_IND_REG_LSB  = 2;
    localparam int MIC_IND_PAGE_LSB = 8;
    localparam int MIC_PAYLOAD_W    = 16;

    // values after reset and fixed values
    localparam logic [31:0] MIC_RST_UPPER_ADDR = 32'h0000_0000;
    localparam logic [15:0] MIC_RST_MSG_DATA   = 16'h0000;
    localparam logic [7:0]  MIC_CAP_CODE       = 8'h0d;
    localparam logic [7:0]  MIC_RST_NXT_PTR    = 8'h00;
    localparam logic [31:0] MIC_RST_SUBSYSTEM_FIELD       = 32'h0000_0000;
    localparam logic [5:0]  MIC_RST_IND_REG    = 6'h00;
    localparam logic [3:0]  MIC_RST_IND_PAGE   = 4'h0;

    typedef enum logic [1:0] {
        MIC_ST_IDLE = 2'b01,
        MIC_ST_EXT  = 2'b10
    } mic_state_e;

endpackage

//--- tb/mic_cfg_regs_props.sv
module mic_cfg_regs_props
    import mic_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_arst_n,
    input wire logic        i_cfg_req,
    input wire logic        i_cfg_smbus,
    input wire logic [9:0]  i_cfg_idx,
    input wire logic [3:0]  i_cfg_be,
    input wire logic        o_cfg_ack,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_ext_req,
    input wire logic        o_ext_wr,
    input wire logic [3:0]  o_ext_be,
    input wire logic        i_ext_ack,
    input wire logic [31:0] i_ext_rdata,
    input wire logic        i_msi_enable,
    input wire logic [29:0] i_lower_msg_address,
    input wire logic        i_msi_fire,
    input wire logic        o_mw_valid,
    input wire logic [63:0] o_mw_addr,
    input wire logic        o_mw_addr64,
    input wire logic [31:0] o_mw_data,
    input wire logic        o_mw_upstream
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    a_mw_issued: assert property (
        i_msi_fire && i_msi_enable |=> o_mw_valid)
        else $error("interrupt write missing");
    a_mw_needs_en: assert property (
        o_mw_valid |-> $past(i_msi_enable) && $past(i_msi_fire))
        else $error("interrupt write while disabled");
    a_mw_aligned: assert property (
        o_mw_valid |->
        o_mw_addr[31:0] == {$past(i_lower_msg_address), 2'b00})
        else $error("interrupt low address wrong");
    a_mw_width: assert property (
        o_mw_valid |-> o_mw_addr64 == (o_mw_addr[63:32] != 32'h0))
        else $error("interrupt address width wrong");
    a_mw_payload: assert property (
        o_mw_valid |-> o_mw_data[31:16] == 16'h0)
        else $error("interrupt payload high half set");
    a_mw_route: assert property (o_mw_valid |-> o_mw_upstream)
        else $error("interrupt write not upstream");
    a_ext_done: assert property (
        o_ext_req && i_ext_ack |=> !o_ext_req && o_cfg_ack &&
        o_cfg_rdata == ($past(o_ext_wr) ? 32'h0 : $past(i_ext_rdata)))
        else $error("forwarded access not completed");
    a_ext_be: assert property (
        $rose(o_ext_req) |-> o_ext_be == $past(i_cfg_be))
        else $error("forwarded byte enables wrong");
    a_smbus_zero: assert property (
        i_cfg_req && i_cfg_smbus && !o_ext_req &&
        i_cfg_idx == MIC_IDX_IND_DATA |=> o_cfg_ack && !o_ext_req &&
        o_cfg_rdata == 32'h0)
        else $error("smbus window access not zero");
endmodule

bind mic_cfg_regs mic_cfg_regs_props u_props (.*);

//--- tb/mic_cfg_space_model.sv
module mic_cfg_space_model
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_req,
    input  wire logic        i_wr,
    input  wire logic [9:0]  i_idx,
    input  wire logic [3:0]  i_be,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_delay,
    output logic             o_ack,
    output logic [31:0]      o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [1024];
    logic [3:0]  cnt_r;
    initial for (int i = 0; i < 1024; i++) mem[i] = 32'h5a00_0000 | i;
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_r <= 4'h0;
            o_ack <= 1'b0;
            o_rdata <= 32'h0;
        end
        else
        begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req && !o_ack)
            begin
                cnt_r <= (cnt_r == i_delay) ? 4'h0 : cnt_r + 4'h1;
                if (cnt_r == i_delay)
                begin
                    o_ack <= 1'b1;
                    o_rdata <= i_wr ? 32'h0 : mem[i_idx];
                    for (int b = 0; b < 4; b++)
                        if (i_wr && i_be[b])
                            mem[i_idx][8*b+:8] <= i_wdata[8*b+:8];
                end
            end
        end
    end
endmodule

//--- tb/test_msi_and_indirect_config_access.sv
module test_msi_and_indirect_config_access;
    timeunit 1ns;
    timeprecision 1ps;
    import mic_pkg::*;
    logic clk, rst_n, req, wr, sm, ea, unl, en, fire;
    logic [9:0]  idx;
    logic [3:0]  be, dly;
    logic [31:0] wd, rd, ed;
    logic [29:0] lo;
    logic        ack, xreq, xwr, mv, m64, mup;
    logic [9:0]  xidx;
    logic [3:0]  xbe;
    logic [31:0] rdata, xwd, md;
    logic [63:0] ma;
    int fail_count, checks_done, cyc;

    mic_cfg_regs u_dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_cfg_req(req),
        .i_cfg_wr(wr), .i_cfg_smbus(sm), .i_cfg_idx(idx), .i_cfg_be(be),
        .i_cfg_wdata(wd), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
        .o_ext_req(xreq), .o_ext_wr(xwr), .o_ext_idx(xidx), .o_ext_be(xbe),
        .o_ext_wdata(xwd), .i_ext_ack(ea), .i_ext_rdata(ed),
        .i_wr_unlock(unl), .i_msi_enable(en), .i_lower_msg_address(lo),
        .i_msi_fire(fire), .o_mw_valid(mv), .o_mw_addr(ma),
        .o_mw_addr64(m64), .o_mw_data(md), .o_mw_upstream(mup));
    mic_cfg_space_model u_space (.i_core_clk(clk), .i_arst_n(rst_n),
        .i_req(xreq), .i_wr(xwr), .i_idx(xidx), .i_be(xbe), .i_wdata(xwd),
        .i_delay(dly), .o_ack(ea), .o_rdata(ed));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            test_done;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic w, s, input logic [9:0] i,
                       input logic [3:0] b, input logic [31:0] d);
        int n;
        {req, wr, sm, idx, be, wd} = {1'b1, w, s, i, b, d};
        @(posedge clk);
        #1 req = 1'b0;
        n = 0;
        while (ack !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        rd = rdata;
        if (n == 40)
            fail_count++;
        @(posedge clk);
        #1;
    endtask

    task automatic w32(input logic [9:0] i, input logic [31:0] d);
        acc(1'b1, 1'b0, i, 4'hf, d);
    endtask

    task automatic r32(input logic [9:0] i, input logic [31:0] e);
        acc(1'b0, 1'b0, i, 4'hf, 32'h0);
        check(rd, e);
    endtask

    task automatic t_defaults;
        r32(MIC_IDX_UPPER_ADDR, 32'h0);
        r32(MIC_IDX_MSG_DATA, 32'h0);
        r32(MIC_IDX_SUBSYSTEM_FIELD_CAP, 32'h0000_000d);
        r32(MIC_IDX_SUBSYSTEM_FIELD, 32'h0);
        r32(MIC_IDX_IND_ADDR, 32'h0);
    endtask

    task automatic t_fields;
        w32(MIC_IDX_SUBSYSTEM_FIELD_CAP, 32'hffff_ffff);
        r32(MIC_IDX_SUBSYSTEM_FIELD_CAP, 32'h0000_000d);
        w32(MIC_IDX_SUBSYSTEM_FIELD, 32'hffff_ffff);
        r32(MIC_IDX_SUBSYSTEM_FIELD, 32'h0);
        unl = 1'b1;
        w32(MIC_IDX_SUBSYSTEM_FIELD_CAP, 32'hffff_ffff);
        r32(MIC_IDX_SUBSYSTEM_FIELD_CAP, 32'h0000_ff0d);
        w32(MIC_IDX_SUBSYSTEM_FIELD, 32'h1234_5678);
        r32(MIC_IDX_SUBSYSTEM_FIELD, 32'h1234_5678);
        w32(MIC_IDX_MSG_DATA, 32'hffff_ffff);
        r32(MIC_IDX_MSG_DATA, 32'h0000_ffff);
        w32(MIC_IDX_IND_ADDR, 32'hffff_ffff);
        r32(MIC_IDX_IND_ADDR, 32'h0000_0ffc);
        w32(10'h010, 32'hffff_ffff);
        r32(10'h010, 32'h0);
    endtask

    task automatic t_window;
        w32(MIC_IDX_IND_ADDR, 32'h0d8);
        w32(MIC_IDX_IND_DATA, 32'hcafe_0001);
        r32(MIC_IDX_UPPER_ADDR, 32'hcafe_0001);
        r32(MIC_IDX_IND_DATA, 32'hcafe_0001);
        w32(MIC_IDX_IND_ADDR, 32'h0fc);
        w32(MIC_IDX_IND_DATA, 32'hffff_ffff);
        r32(MIC_IDX_IND_DATA, 32'h0);
        r32(MIC_IDX_UPPER_ADDR, 32'hcafe_0001);
        w32(MIC_IDX_IND_ADDR, 32'h1a4);
        r32(MIC_IDX_IND_DATA, 32'h5a00_0069);
        dly = 4'h3;
        acc(1'b1, 1'b0, MIC_IDX_IND_DATA, 4'b0010, 32'hffff_ffff);
        r32(MIC_IDX_IND_DATA, 32'h5a00_ff69);
        acc(1'b0, 1'b1, MIC_IDX_IND_DATA, 4'hf, 32'h0);
        check(rd, 32'h0);
        acc(1'b1, 1'b1, MIC_IDX_IND_DATA, 4'hf, 32'h0);
        r32(MIC_IDX_IND_DATA, 32'h5a00_ff69);
    endtask

    task automatic msi(input logic e, input logic [63:0] a, input logic a64);
        en = e;
        fire = 1'b1;
        @(posedge clk);
        #1 fire = 1'b0;
        check(mv, e);
        if (e)
        begin
            check(ma, a);
            check(m64, a64);
            check(md, 32'h0000_ffff);
            check(mup, 1'b1);
        end
        @(posedge clk);
        #1;
    endtask

    task automatic t_msi;
        lo = 30'h0400_0001;
        w32(MIC_IDX_UPPER_ADDR, 32'h0);
        msi(1'b1, 64'h0000_0000_1000_0004, 1'b0);
        w32(MIC_IDX_UPPER_ADDR, 32'h1);
        msi(1'b1, 64'h0000_0001_1000_0004, 1'b1);
        msi(1'b0, 64'h0, 1'b0);
    endtask

    task automatic t_reset;
        rst_n = 1'b0;
        @(posedge clk);
        #1 check(ack, 1'b0);
        check(xreq, 1'b0);
        check(mv, 1'b0);
        @(posedge clk);
        #1 rst_n = 1'b1;
        t_defaults;
    endtask

    initial
    begin
        {rst_n, req, wr, sm, unl, en, fire, idx, be, wd, lo, dly} = '0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        t_defaults;
        t_fields;
        t_window;
        t_msi;
        t_reset;
        test_done;
    end
endmodule
